/* tb/lam_core_properties.sv */
// checker: memory bus and register bus timing of the load address unit
// assumes: bound to lam_core and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module lam_core_properties
   import lam_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic MEM_IO,
   input wire lam_pkg::dtype_e MEM_TYPE,
   input wire logic MEM_ACK,
   input wire logic MEM_ERR
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   logic ph; // set between the two words of a pair
   wire dfirst = MEM_REQ && MEM_ACK && !MEM_ERR && MEM_TYPE == DT_D && !ph;
   // tracks first or second word of a double transfer
   always_ff @(posedge MCLK) begin
      if (SRST)
         ph <= 1'b0;
      else if (MEM_REQ && MEM_ACK && MEM_TYPE == DT_D)
         ph <= !ph && !MEM_ERR;
   end
   mem_pair_a: assert property (
      dfirst && !MEM_IO |=> !MEM_REQ ##1
      MEM_REQ && MEM_ADDR == $past(MEM_ADDR, 2) + PAIR_STEP)
      else $error("memory pair address wrong");
   io_pair_a: assert property (
      dfirst && MEM_IO |=> !MEM_REQ ##1
      MEM_REQ && MEM_IO && MEM_ADDR == $past(MEM_ADDR, 2) + PAIR_STEP)
      else $error("io pair address wrong");
   io_type_a: assert property (
      MEM_REQ && MEM_IO |-> MEM_TYPE inside {DT_W, DT_D})
      else $error("io access of illegal width");
   type_legal_a: assert property (
      MEM_REQ |-> MEM_TYPE <= DT_D) else $error("unknown data type");
   addr_hold_a: assert property (
      MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) &&
      $stable(MEM_TYPE)) else $error("request changed before ack");
   word_once_a: assert property (
      MEM_REQ && MEM_ACK && MEM_TYPE != DT_D |=> !MEM_REQ [*2])
      else $error("single transfer repeated");
   bvalid_hold_a: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write response dropped");
   rvalid_hold_a: assert property (RVALID && !RREADY |=> RVALID)
      else $error("read data dropped");
endmodule : lam_core_properties
`default_nettype wire

/* tb/lam_mem_model.sv */
// model: memory and io bus of the core, prompt or slow answers
// assumes: one-cycle ack answers a held request
`timescale 1ns/1ns
`default_nettype none
module lam_mem_model (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic slow,
   input wire logic err_on,
   output logic MEM_ACK,
   output logic MEM_ERR,
   output logic [31:0] MEM_RDATA
);
   logic [1:0] cnt; // wait states spent on this request
   wire hit = MEM_REQ && !MEM_ACK && cnt == (slow ? 2'h3 : 2'h0);
   // data is a pattern of the address; idle lines toggle every cycle
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         MEM_ACK <= 1'b0;
         MEM_ERR <= 1'b0;
         MEM_RDATA <= 32'h0;
         cnt <= 2'h0;
      end else begin
         MEM_ACK <= hit;
         cnt <= (MEM_REQ && !hit && !MEM_ACK) ? cnt + 2'h1 : 2'h0;
         MEM_ERR <= hit ? err_on : !MEM_ERR;
         MEM_RDATA <= hit ? {MEM_ADDR[15:0], ~MEM_ADDR[15:0]} : ~MEM_RDATA;
      end
   end
endmodule : lam_mem_model
`default_nettype wire

/* tb/load_address_mode_unit_bench.sv */
// bench: runs each load mode through the register port
// assumes: lam_core, lam_mem_model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module load_address_mode_unit_bench;
   import lam_pkg::*;
   logic MCLK = 1'b0;
   logic SRST = 1'b1;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, b, v;
   logic [3:0] WSTRB = 4'hf;
   logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic slow = 0, err_on = 0;
   logic [1:0] rr;
   wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_REQ, MEM_IO;
   wire logic MEM_ACK, MEM_ERR;
   wire logic [1:0] BRESP, RRESP;
   wire logic [31:0] RDATA, MEM_ADDR, MEM_RDATA;
   dtype_e MEM_TYPE;
   int bad_count = 0, checked = 0, cyc = 0, seed = 39151;
   lam_core uut (.MCLK, .SRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
      .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
      .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .MEM_REQ, .MEM_ADDR,
      .MEM_IO, .MEM_TYPE, .MEM_ACK, .MEM_ERR, .MEM_RDATA);
   lam_mem_model mem (.MCLK, .SRST, .MEM_REQ, .MEM_ADDR, .slow, .err_on,
      .MEM_ACK, .MEM_ERR, .MEM_RDATA);
   initial forever #5 MCLK = ~MCLK;
   // cut a hang short
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input string n, input logic [31:0] e, s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // write: each channel dropped at the rising edge that takes it
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      BREADY <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      v = RDATA;
      rr = RRESP;
      RREADY <= 1'b0;
   endtask : rd
   function automatic logic [31:0] md(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction : md
   function automatic logic [31:0] cv(input logic [31:0] d, input dtype_e t);
      case (t)
         DT_BU: return {24'h0, d[7:0]};
         DT_BS: return {{24{d[7]}}, d[7:0]};
         DT_HU: return {16'h0, d[15:0]};
         DT_HS: return {{16{d[15]}}, d[15:0]};
         default: return d;
      endcase
   endfunction : cv
   // one load: base b in register bi, result in di and its follower
   task go(input logic [15:0] h1, h2, h3, input int bi, di,
      input logic [31:0] ea, eu, input dtype_e t);
      int d2;
      d2 = (di & 16) | ((di + 1) & 15);
      slow <= 1'($random(seed));
      wr(8'h80 + 8'(bi * 4), b);
      wr(OFS_INSTR, {h1, h2});
      wr(OFS_EXT, {16'h0, h3});
      wr(OFS_CTRL, 32'h1);
      repeat (40) begin
         rd(OFS_CTRL);
         if (v[ST_DONE] === 1'b1) break;
      end
      chk("status", {29'h0, err_on, 2'h2}, v);
      rd(OFS_ADDR);
      chk("address", ea, v);
      rd(8'h80 + 8'(bi * 4));
      chk("base", eu, v);
      if (!err_on) begin
         rd(8'h80 + 8'(di * 4));
         chk("dest", cv(md(ea), t), v);
         if (t == DT_D) begin
            rd(8'h80 + 8'(d2 * 4));
            chk("pair", md(ea + PAIR_STEP), v);
         end
      end
      $display("load %h finished", h1);
   endtask : go
   initial begin
      repeat (6) @(posedge MCLK);
      SRST <= 1'b0;
      rd(OFS_CTRL);
      chk("ctrl", 32'h0, v);
      chk("type", 32'(DT_W), 32'(MEM_TYPE));
      rd(8'h40);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rr});
      repeat (2) begin
         b = 32'($random(seed)) & 32'h00ff_fff8;
         go({OP_LDD_POSTINC, 1'b0, 8'h34}, 0, 0, 19, 4, b, b + 8, DT_D);
         go({OP_LDD_REG, 1'b1, 8'h36}, 0, 0, 19, 22, b, b, DT_D);
         go({OP_LDW_POSTINC, 1'b0, 8'h38}, 0, 0, 19, 8, b, b + 4, DT_W);
         go({7'h68, 1'b1, 8'h38}, 0, 0, 19, 24, b, b, DT_W);
         go({OP_DISP, 2'h1, 8'h79}, {4'h5, 12'hf00}, 0, 7, 25, b - 32'h100,
            b, DT_BS);
         go({OP_DISP, 2'h1, 8'h79}, {4'h2, 12'h020}, 0, 7, 25, b + 32'h20,
            b, DT_HU);
         go({OP_DISP, 2'h0, 8'h12}, {4'h8, 12'h123}, 16'h4567, 1, 2,
            32'h0123_4567, b, DT_BU);
         go({OP_DISP, 2'h0, 8'h12}, {4'h3, 12'h102}, 0, 1, 2, 32'h100, b,
            DT_W);
         go({OP_DISP, 2'h0, 8'h7a}, {4'h3, 12'h013}, 0, 7, 10, b + 32'h10,
            b, DT_D);
         go({OP_NEXT, 2'h0, 8'h7b}, {4'h2, 12'h0a5}, 0, 7, 11, b,
            b + 32'ha4, DT_HS);
         go({OP_NEXT, 2'h0, 8'h7b}, {4'h7, 12'hff1}, 0, 7, 11, b,
            b - 32'h10, DT_D);
         go({OP_NEXT, 2'h0, 8'h7b}, {4'h0, 12'h003}, 0, 7, 11, b, b + 3,
            DT_BU);
      end
      err_on <= 1'b1;
      go({OP_LDW_POSTINC, 1'b0, 8'h38}, 0, 0, 19, 8, b, b + 4, DT_W);
      go({OP_LDD_POSTINC, 1'b0, 8'h34}, 0, 0, 19, 4, b, b + 8, DT_D);
      tally_and_finish();
   end
endmodule : load_address_mode_unit_bench
bind lam_core lam_core_properties u_props (.MCLK, .SRST, .BVALID, .BREADY,
   .RVALID, .RREADY, .MEM_REQ, .MEM_ADDR, .MEM_IO, .MEM_TYPE, .MEM_ACK,
   .MEM_ERR);
`default_nettype wire

/* verilog/lam_addr.sv */
// module: effective address and write-back value of the address register
// assumes: base value read from the register file for base_idx
`timescale 1ns/1ns
`default_nettype none
module lam_addr (
   lam_dec_if.dst d,
   input wire logic [31:0] base_val,
   output logic [31:0] addr,
   output logic [31:0] upd,
   output logic upd_en
);
   import lam_pkg::*;
   // ====================
   // mode groups
   wire m_abs = (d.mode == M_ABS) || (d.mode == M_IO_ABS);
   wire m_sum = (d.mode == M_DISP) || (d.mode == M_IO_DISP);
   wire m_pinc = (d.mode == M_LDD_POSTINC) || (d.mode == M_LDW_POSTINC);
   wire [31:0] sum = base_val + d.disp;                 // [RULE9] [RULE12]
   wire [31:0] step = d.dbl ? INC_DOUBLE : INC_WORD;     // [RULE1] [RULE18]
   // ====================
   // absolute ignores the base; register, post-increment and next use it
   assign addr = m_abs ? d.disp : m_sum ? sum : base_val; // [RULE10] [RULE14]
   assign upd = m_pinc ? (base_val + step) : sum;           // [RULE14]
   assign upd_en = m_pinc || (d.mode == M_NEXT);            // [RULE2] [RULE19]
endmodule : lam_addr
`default_nettype wire

/* verilog/lam_core.sv */
// module: load address mode unit with register file and axi4-lite port
// assumes: memory bus answers each request with a one-cycle MEM_ACK
//
// Summary of operation
// RULE1: double post-increment adds eight on first cycle
// RULE2: double register mode keeps address register
// RULE3: short format bit 8 picks destination bank
// RULE4: base and destination banks decode independently
// RULE5: short displacement sign-extended by twenty bits
// RULE6: long displacement uses extra halfword
// RULE7: data type from field D13..D12
// RULE8: byte, halfword, word, double memory types
// RULE9: displacement address is base plus displacement
// RULE10: status register base means absolute address
// RULE11: i/o absolute issues displacement in i/o space
// RULE12: i/o displacement adds base, pair at plus four
// RULE13: i/o loads only word or double
// RULE14: next-address updates base even on exception
// RULE15: software never names program counter or status
// RULE16: non-byte next-address clears displacement bit zero
// RULE17: double next-address second word at old+4
// RULE18: word post-increment adds four always
// RULE19: word register mode keeps register, no exception
// RULE20: pair fills destination then following register
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module lam_core #(
   parameter int ADDR_W = 8,             // axi byte address width
   parameter logic [6:0] LDW_REG_OP = 7'h68
) (
   input wire logic MCLK,
   input wire logic SRST,
   // axi4-lite write channels
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read channels
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // memory and i/o bus
   output logic MEM_REQ,
   output logic [31:0] MEM_ADDR,
   output logic MEM_IO,
   output lam_pkg::dtype_e MEM_TYPE,
   input wire logic MEM_ACK,
   input wire logic MEM_ERR,
   input wire logic [31:0] MEM_RDATA
);
   import lam_pkg::*;
   // ====================
   // state
   state_e state;                 // sequencer
   logic [31:0] instr;            // hw1 in upper half, hw2 in lower
   logic [15:0] ext_hw;           // optional third halfword
   logic done;                    // last operation finished
   logic err;                     // bus error reported
   logic ill;                     // last start held unknown code
   logic [31:0] last_addr;        // first address of last operation
   logic [ADDR_W-1:0] waddr;      // captured write address
   logic [31:0] wdata;            // captured write data
   logic [3:0] wstrb;             // captured byte enables
   logic [31:0] regs [32];        // G0..G15 then L0..L15
   // ====================
   // decode and address generation
   lam_dec_if dec ();
   assign dec.hw1 = instr[31:16];
   assign dec.hw2 = instr[15:0];
   assign dec.hw3 = ext_hw;
   lam_decode #(
      .LDW_REG_OP(LDW_REG_OP)
   ) u_decode (
      .d(dec)
   );
   wire [31:0] base_val = regs[dec.base_idx];
   wire [31:0] ea;
   wire [31:0] upd;
   wire upd_en;
   lam_addr u_addr (
      .d(dec),
      .base_val(base_val),
      .addr(ea),
      .upd(upd),
      .upd_en(upd_en)
   );
   // ====================
   // axi write decode
   wire idle = (state == S_IDLE);
   wire wr_fire = !AWREADY && !WREADY && !BVALID;   // both halves held
   wire w_rf = waddr[RF_SEL_BIT] && (waddr[ADDR_W-1:RF_SEL_BIT+1] == '0);
   wire w_ctrl = (waddr == ADDR_W'(OFS_CTRL));
   wire w_instr = (waddr == ADDR_W'(OFS_INSTR));
   wire w_ext = (waddr == ADDR_W'(OFS_EXT));
   wire w_ro = (waddr == ADDR_W'(OFS_ADDR)) || (waddr == ADDR_W'(OFS_INFO));
   wire w_map = w_rf || w_ctrl || w_instr || w_ext || w_ro;
   wire [4:0] w_idx = waddr[6:2];
   wire start = wr_fire && w_ctrl && wstrb[0] && wdata[CTRL_START] && idle;
   // byte-lane merge of captured data into an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge
   // ====================
   // load data extension by type
   wire [31:0] ld_data =
      (MEM_TYPE == DT_BU) ? {24'h000000, MEM_RDATA[7:0]} :        // [RULE8]
      (MEM_TYPE == DT_BS) ? {{24{MEM_RDATA[7]}}, MEM_RDATA[7:0]} :
      (MEM_TYPE == DT_HU) ? {16'h0000, MEM_RDATA[15:0]} :
      (MEM_TYPE == DT_HS) ? {{16{MEM_RDATA[15]}}, MEM_RDATA[15:0]} :
      MEM_RDATA;
   // ====================
   // register file write port: sequencer or idle software
   wire [4:0] pair_idx = {dec.dst_idx[4], dec.dst_idx[3:0] + 4'h1}; // [RULE20]
   wire upd_we = (state == S_FIRST) && upd_en;      // [RULE1] [RULE14] [RULE18]
   wire d1_we = (state == S_WAIT1) && MEM_ACK && !MEM_ERR;
   wire d2_we = (state == S_WAIT2) && MEM_ACK && !MEM_ERR;
   wire sw_we = wr_fire && w_rf && idle;
   wire rf_we = upd_we || d1_we || d2_we || sw_we;
   wire [4:0] rf_idx = upd_we ? dec.base_idx : d1_we ? dec.dst_idx :
      d2_we ? pair_idx : w_idx;                                  // [RULE20]
   wire [31:0] rf_data = upd_we ? upd : (d1_we || d2_we) ? ld_data :
      merge(regs[w_idx], wdata, wstrb);
   // one write port, one entry per generate step
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_rf
         always_ff @(posedge MCLK) begin
            if (SRST) begin
               regs[gi] <= 32'h0000_0000;
            end else if (rf_we && (rf_idx == 5'(gi))) begin
               regs[gi] <= rf_data;
            end
         end
      end
   endgenerate
   // ====================
   // axi write channels: take address and data in either order
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
         waddr <= '0;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
      end else begin
         // capture address
         if (AWVALID && AWREADY) begin
            waddr <= AWADDR;
            AWREADY <= 1'b0;
         end
         // capture data
         if (WVALID && WREADY) begin
            wdata <= WDATA;
            wstrb <= WSTRB;
            WREADY <= 1'b0;
         end
         // answer once both are held
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= w_map ? RESP_OKAY : RESP_SLVERR;
         end
         // response taken, reopen both channels
         if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end
   // ====================
   // software-written registers, frozen while an operation runs
   wire [31:0] ext_new = merge({16'h0000, ext_hw}, wdata, wstrb);
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         instr <= INSTR_RST;
         ext_hw <= EXT_RST;
      end else if (wr_fire && idle) begin
         if (w_instr) begin
            instr <= merge(instr, wdata, wstrb);
         end
         if (w_ext) begin
            ext_hw <= ext_new[15:0];
         end
      end
   end
   // ====================
   // axi read channel: data one cycle after the address is taken
   wire [4:0] r_idx = ARADDR[6:2];
   wire r_rf = ARADDR[RF_SEL_BIT] && (ARADDR[ADDR_W-1:RF_SEL_BIT+1] == '0);
   wire [31:0] info = {21'h000000, dec.dbl, dec.io,
      (dec.ext ? 2'h3 : 2'h2), dec.dtype, dec.mode};
   wire [31:0] status = {28'h0000000, ill, err, done, !idle};
   wire r_map = r_rf || (ARADDR == ADDR_W'(OFS_CTRL)) ||
      (ARADDR == ADDR_W'(OFS_INSTR)) || (ARADDR == ADDR_W'(OFS_EXT)) ||
      (ARADDR == ADDR_W'(OFS_ADDR)) || (ARADDR == ADDR_W'(OFS_INFO));
   wire [31:0] rd_mux =
      r_rf ? regs[r_idx] :
      (ARADDR == ADDR_W'(OFS_CTRL)) ? status :
      (ARADDR == ADDR_W'(OFS_INSTR)) ? instr :
      (ARADDR == ADDR_W'(OFS_EXT)) ? {16'h0000, ext_hw} :
      (ARADDR == ADDR_W'(OFS_ADDR)) ? last_addr :
      (ARADDR == ADDR_W'(OFS_INFO)) ? info : 32'h0000_0000;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         // take the address, answer next cycle
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RDATA <= rd_mux;
         RRESP <= r_map ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
         ARREADY <= 1'b1;
      end
   end
   // ====================
   // error reporting: register modes raise no exception
   wire quiet = (dec.mode == M_LDD_REG) || (dec.mode == M_LDW_REG);
   wire ack_err = MEM_ACK && MEM_ERR && !quiet;            // [RULE2] [RULE19]
   // ====================
   // load sequencer
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state <= S_IDLE;
         MEM_REQ <= 1'b0;
         MEM_ADDR <= 32'h0000_0000;
         MEM_IO <= 1'b0;
         MEM_TYPE <= DT_W;
         done <= 1'b0;
         err <= 1'b0;
         ill <= 1'b0;
         last_addr <= 32'h0000_0000;
      end else begin
         unique case (state)
            S_IDLE: begin
               // a start clears old flags; unknown code ends at once
               if (start) begin
                  err <= 1'b0;
                  ill <= dec.illegal;
                  done <= dec.illegal;
                  state <= dec.illegal ? S_IDLE : S_FIRST;
               end
            end
            S_FIRST: begin
               // first request; base write-back happens this cycle
               MEM_REQ <= 1'b1;
               MEM_ADDR <= ea;                       // [RULE9] [RULE10]
               MEM_IO <= dec.io;                     // [RULE11] [RULE12]
               MEM_TYPE <= dec.dtype;                // [RULE7]
               last_addr <= ea;
               state <= S_WAIT1;
            end
            S_WAIT1: begin
               // first word lands in the destination register
               if (MEM_ACK) begin
                  MEM_REQ <= 1'b0;
                  err <= ack_err;
                  if (dec.dbl && !MEM_ERR) begin
                     state <= S_SECOND;
                  end else begin
                     done <= 1'b1;
                     state <= S_IDLE;
                  end
               end
            end
            S_SECOND: begin
               // second word from the first address plus four
               MEM_REQ <= 1'b1;
               MEM_ADDR <= MEM_ADDR + PAIR_STEP;    // [RULE12] [RULE17]
               state <= S_WAIT2;
            end
            S_WAIT2: begin
               // second word lands in the following register
               if (MEM_ACK) begin
                  MEM_REQ <= 1'b0;
                  err <= ack_err;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end
endmodule : lam_core
`default_nettype wire

/* verilog/lam_dec_if.sv */
// interface: decoded instruction between decoder, address unit and core
// assumes: the core drives the three instruction halfwords from its software-written registers
`timescale 1ns/1ns
`default_nettype none
interface lam_dec_if;
   import lam_pkg::*;
   logic [15:0] hw1;        // opcode halfword
   logic [15:0] hw2;        // displacement halfword
   logic [15:0] hw3;        // extension halfword
   mode_e mode;             // decoded address mode
   dtype_e dtype;           // decoded data type
   logic [4:0] dst_idx;     // destination, bank in bit 4
   logic [4:0] base_idx;    // address register, bank in bit 4
   logic [31:0] disp;       // sign-extended, aligned displacement
   logic io;                // i/o space access
   logic dbl;               // register pair transfer
   logic ext;               // third halfword used
   logic illegal;           // unknown encoding
   modport src (input hw1, hw2, hw3, output mode, dtype, dst_idx,
      base_idx, disp, io, dbl, ext, illegal);
   modport dst (input mode, dtype, dst_idx, base_idx, disp, io, dbl,
      ext, illegal);
endinterface : lam_dec_if
`default_nettype wire

/* verilog/lam_decode.sv */
// module: combinational decoder of the load instruction group
// assumes: halfwords are stable while an operation runs
`timescale 1ns/1ns
`default_nettype none
module lam_decode #(
   parameter logic [6:0] LDW_REG_OP = 7'h68  // word register-mode opcode
) (
   lam_dec_if.src d
);
   import lam_pkg::*;
   // ====================
   // field split
   wire [6:0] op7 = d.hw1[15:9];
   wire [5:0] op6 = d.hw1[15:10];
   wire [1:0] dd = d.hw2[F_DD_LO+1:F_DD_LO];
   wire [11:0] dis1 = d.hw2[11:0];
   wire sign = d.hw2[F_SIGN];
   wire is_lr = (op7 == OP_LDD_POSTINC) || (op7 == OP_LDD_REG) ||
      (op7 == OP_LDW_POSTINC) || (op7 == LDW_REG_OP);
   wire is_disp = (op6 == OP_DISP);
   wire is_next = (op6 == OP_NEXT);
   wire is_rr = is_disp || is_next;
   // register banks: clear is global, set is local
   wire [4:0] lr_base = {1'b1, d.hw1[7:4]};                       // [RULE3]
   wire [4:0] rr_base = {d.hw1[F_BASE_BANK], d.hw1[7:4]};         // [RULE4]
   wire [4:0] dst = {d.hw1[F_DST_BANK], d.hw1[3:0]};       // [RULE3] [RULE4]
   wire base_sr = (rr_base == {1'b0, SR_CODE});                   // [RULE10]
   // ====================
   // displacement, short or long form
   wire [31:0] raw = d.ext ? {{4{sign}}, dis1, d.hw3}            // [RULE6]
                           : {{20{sign}}, dis1};                   // [RULE5]
   // data type from D13..D12, subtype in low displacement bits
   wire [2:0] half_t = dis1[0] ? DT_HS : DT_HU;
   wire [2:0] word_t = dis1[0] ? DT_D : DT_W;
   wire [2:0] rr_t = (dd == DD_BU) ? DT_BU : (dd == DD_BS) ? DT_BS :
      (dd == DD_HALF) ? half_t : word_t;                 // [RULE7] [RULE8]
   // i/o space exists only for word and double               [RULE13]
   wire rr_io = (dd == DD_WORD) && dis1[1];
   // subtype bits read as zero in the address; bit zero is
   // dropped for all types but byte                          [RULE16]
   wire [31:0] mask = (dd == DD_WORD) ? 32'h0000_0003 :
      (dd == DD_HALF) ? 32'h0000_0001 : 32'h0000_0000;
   // ====================
   // outputs
   assign d.ext = is_rr && d.hw2[F_EXT];
   assign d.disp = raw & ~mask;
   assign d.io = is_rr && rr_io;
   assign d.base_idx = is_lr ? lr_base : rr_base;
   assign d.dst_idx = dst;
   assign d.dtype = is_lr ? (op7[0] ? DT_D : DT_W)
                          : dtype_e'(rr_t);
   assign d.dbl = is_lr ? (op7[0] == 1'b1) : (word_t == DT_D) &&
      (dd == DD_WORD);
   assign d.illegal = !(is_lr || is_rr) || (is_next && rr_io);
   assign d.mode =
      (op7 == OP_LDD_POSTINC) ? M_LDD_POSTINC :
      (op7 == OP_LDD_REG) ? M_LDD_REG :
      (op7 == OP_LDW_POSTINC) ? M_LDW_POSTINC :
      (op7 == LDW_REG_OP) ? M_LDW_REG :
      (is_next && !rr_io) ? M_NEXT :
      (is_disp && rr_io) ? (base_sr ? M_IO_ABS : M_IO_DISP) :  // [RULE11]
      is_disp ? (base_sr ? M_ABS : M_DISP) : M_NONE;           // [RULE10]
endmodule : lam_decode
`default_nettype wire

/* verilog/lam_pkg.sv */
// package: constants, encodings and types of the load address unit
// assumes: 32-bit data, AXI4-Lite register port with 8-bit byte address
package lam_pkg;
   // ====================
   // register map (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;  // start / status
   localparam logic [7:0] OFS_INSTR = 8'h04; // first and second halfword
   localparam logic [7:0] OFS_EXT = 8'h08;   // extension halfword
   localparam logic [7:0] OFS_ADDR = 8'h0c;  // first address of last operation
   localparam logic [7:0] OFS_INFO = 8'h10;  // decoded instruction info
   localparam int RF_SEL_BIT = 7;            // set: register file window
   // ====================
   // control / status bit positions
   localparam int CTRL_START = 0;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR = 2;
   localparam int ST_ILL = 3;
   // reset values
   localparam logic [31:0] INSTR_RST = 32'h0000_0000;
   localparam logic [15:0] EXT_RST = 16'h0000;
   // ====================
   // opcodes and instruction fields
   localparam logic [6:0] OP_LDD_POSTINC = 7'h6b; // 1101 011
   localparam logic [6:0] OP_LDD_REG = 7'h69;     // 1101 001
   localparam logic [6:0] OP_LDW_POSTINC = 7'h6a; // 1101 010
   localparam logic [5:0] OP_DISP = 6'h24;        // 1001 00
   localparam logic [5:0] OP_NEXT = 6'h25;        // 1001 01
   localparam int F_EXT = 15;     // e bit of second halfword
   localparam int F_SIGN = 14;    // S bit
   localparam int F_DD_LO = 12;   // data type field D13..D12
   localparam int F_BASE_BANK = 9;
   localparam int F_DST_BANK = 8;
   localparam logic [3:0] SR_CODE = 4'h1;  // status register is G1
   localparam logic [1:0] DD_BU = 2'h0;
   localparam logic [1:0] DD_BS = 2'h1;
   localparam logic [1:0] DD_HALF = 2'h2;
   localparam logic [1:0] DD_WORD = 2'h3;
   // ====================
   // address steps
   localparam logic [31:0] INC_DOUBLE = 32'h0000_0008;
   localparam logic [31:0] INC_WORD = 32'h0000_0004;
   localparam logic [31:0] PAIR_STEP = 32'h0000_0004;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ====================
   // types
   typedef enum logic [2:0] {
      DT_BU = 3'h0, DT_BS = 3'h1, DT_HU = 3'h2,
      DT_HS = 3'h3, DT_W = 3'h4, DT_D = 3'h5
   } dtype_e;
   typedef enum logic [3:0] {
      M_NONE = 4'h0, M_LDD_POSTINC = 4'h1, M_LDD_REG = 4'h2,
      M_LDW_POSTINC = 4'h3, M_LDW_REG = 4'h4, M_DISP = 4'h5,
      M_ABS = 4'h6, M_IO_ABS = 4'h7, M_IO_DISP = 4'h8, M_NEXT = 4'h9
   } mode_e;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001, S_FIRST = 5'b00010, S_WAIT1 = 5'b00100,
      S_SECOND = 5'b01000, S_WAIT2 = 5'b10000
   } state_e;
endpackage : lam_pkg
